/* rtl/gpio_consts.svh */
// Register offsets, reset values and field positions of the GPIO port block
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
`define ADDR_W          5
`define OFF_DATA_A      5'h00
`define OFF_DATA_B      5'h01
`define OFF_DATA_C      5'h02
`define OFF_DATA_D      5'h03
`define OFF_DIR_A       5'h04
`define OFF_DIR_B       5'h05
`define OFF_DIR_C       5'h06
`define OFF_DIR_D       5'h07
`define OFF_WAKE_EN     5'h08
`define OFF_DRIVE_LOW   5'h09
`define OFF_DRIVE_HIGH  5'h0a
`define OFF_HALT_CTRL   5'h0b
`define OFF_IRQ_STATUS  5'h0c
`define OFF_IRQ_MASK    5'h0d
`define RST_DIR         8'hff
`define RST_WAKE_EN     8'h00
`define RST_DRIVE       8'h00
`define RST_DATA        8'h00
`define BIT_IRQ_WAKE    0
`define BIT_IRQ_EDGE    1
`define DRV_B_HI_POS    6
`define DRV_B_LO_POS    4
`define DRV_A_HI_POS    2
`define DRV_A_LO_POS    0
`define DRV_C_HI_POS    2
`define DRV_C_LO_POS    0
`endif

/* rtl/gpio_pkg.sv */
// Types shared by the GPIO port block
package gpio_pkg;
   typedef enum logic [1:0] {
      DRIVE_LEVEL0,
      DRIVE_LEVEL1,
      DRIVE_LEVEL2,
      DRIVE_LEVEL3
   } drive_level_t;
   typedef enum logic {
      RUN_MODE,
      HALT_MODE
   } power_state_t;
endpackage

/* rtl/gpio_direction_wake_drive.sv */
// GPIO port with direction control, port A wake-up and drive level selects
// Operation
// - Falling edge on enabled pin wakes halted core
// - Eight wake enables, one per pin, reset zero
// - Wake only for input pins while halted
// - Direction one is input, zero output
// - One direction bit per pin, changeable anytime
// - Input pin reads actual pin level
// - Output pin reads output latch value
// - Output latch holds until rewritten
// - Two-bit code selects drive level 0..3
// - Drive select affects only output pins
// - Low drive register groups ports A and B
// - High drive register groups port C pins
`timescale 1ns/1ns
`include "gpio_consts.svh"
module gpio_direction_wake_drive #(
   parameter int PORT_W = 8
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic [`ADDR_W-1:0]   bus_addr,
   input  wire logic [7:0]           bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic      [7:0]           bus_rdata,
   input  wire logic [PORT_W-1:0]    pin_a_in,
   input  wire logic [PORT_W-1:0]    pin_b_in,
   input  wire logic [PORT_W-1:0]    pin_c_in,
   input  wire logic [PORT_W-1:0]    pin_d_in,
   output logic      [PORT_W-1:0]    pin_a_out,
   output logic      [PORT_W-1:0]    pin_b_out,
   output logic      [PORT_W-1:0]    pin_c_out,
   output logic      [PORT_W-1:0]    pin_d_out,
   output logic      [PORT_W-1:0]    pin_a_oe_n,
   output logic      [PORT_W-1:0]    pin_b_oe_n,
   output logic      [PORT_W-1:0]    pin_c_oe_n,
   output logic      [PORT_W-1:0]    pin_d_oe_n,
   output logic      [2*PORT_W-1:0]  drive_a_level,
   output logic      [2*PORT_W-1:0]  drive_b_level,
   output logic      [2*PORT_W-1:0]  drive_c_level,
   output logic                      halted,
   output logic                      wake_req,
   output logic                      irq
);

   // Synchroniser stages, first stage feeds only the second
   logic [PORT_W-1:0] sync1_a, sync1_b, sync1_c, sync1_d;
   logic [PORT_W-1:0] sync2_a, sync2_b, sync2_c, sync2_d;
   logic [PORT_W-1:0] prev_a;             // Previous synced port A sample

   // Register state
   logic [PORT_W-1:0] data_a_reg, data_b_reg, data_c_reg, data_d_reg;
   logic [PORT_W-1:0] dir_a_reg, dir_b_reg, dir_c_reg, dir_d_reg;
   logic [7:0]        wake_en_reg;        // Port A wake enables
   logic [7:0]        drive_low_reg;      // Ports A and B drive selects
   logic [7:0]        drive_high_reg;     // Port C selects plus reserved
   logic [1:0]        irq_status_reg;     // Sticky events
   logic [1:0]        irq_mask_reg;       // Interrupt enables
   gpio_pkg::power_state_t pwr_reg;       // Run or halted
   logic              wake_reg;           // Wake request pulse
   logic [7:0]        rdata_reg;          // Read data, one cycle later

   // Next values
   logic [PORT_W-1:0] data_a_next, data_b_next, data_c_next, data_d_next;
   logic [PORT_W-1:0] dir_a_next, dir_b_next, dir_c_next, dir_d_next;
   logic [7:0]        wake_en_next, drive_low_next, drive_high_next;
   logic [1:0]        irq_status_next, irq_mask_next;
   gpio_pkg::power_state_t pwr_next;
   logic              wake_next;
   logic [7:0]        rdata_next;

   // Derived signals
   logic [PORT_W-1:0] fall_a;             // Falling edges on port A
   logic [PORT_W-1:0] wake_hit;           // Edges qualified for wake
   logic [1:0]        events;             // Event set terms

   // Pin synchronisers and edge history
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_a <= '0;
         sync1_b <= '0;
         sync1_c <= '0;
         sync1_d <= '0;
         sync2_a <= '0;
         sync2_b <= '0;
         sync2_c <= '0;
         sync2_d <= '0;
         prev_a  <= '0;
      end else begin
         sync1_a <= pin_a_in;
         sync1_b <= pin_b_in;
         sync1_c <= pin_c_in;
         sync1_d <= pin_d_in;
         sync2_a <= sync1_a;
         sync2_b <= sync1_b;
         sync2_c <= sync1_c;
         sync2_d <= sync1_d;
         prev_a  <= sync2_a;
      end
   end

   // Edge detect on synchronised samples
   always_comb begin
      fall_a   = prev_a & ~sync2_a;
      // Enabled, input, and core halted
      wake_hit = fall_a & wake_en_reg & dir_a_reg
                 & {PORT_W{pwr_reg == gpio_pkg::HALT_MODE}};
   end

   // Read mux: input pins give level, output pins give latch
   function automatic logic [PORT_W-1:0] port_read(
      input logic [PORT_W-1:0] dir,
      input logic [PORT_W-1:0] latch,
      input logic [PORT_W-1:0] level
   );
      port_read = (dir & level) | (~dir & latch);
   endfunction

   // Next state of registers, power state and read data
   always_comb begin
      data_a_next     = data_a_reg;
      data_b_next     = data_b_reg;
      data_c_next     = data_c_reg;
      data_d_next     = data_d_reg;
      dir_a_next      = dir_a_reg;
      dir_b_next      = dir_b_reg;
      dir_c_next      = dir_c_reg;
      dir_d_next      = dir_d_reg;
      wake_en_next    = wake_en_reg;
      drive_low_next  = drive_low_reg;
      drive_high_next = drive_high_reg;
      irq_mask_next   = irq_mask_reg;
      pwr_next        = pwr_reg;
      wake_next       = 1'b0;
      rdata_next      = 8'h00;
      events          = 2'b00;
      // Write decode
      if (bus_wr) begin
         unique case (bus_addr)
            `OFF_DATA_A:     data_a_next     = bus_wdata;
            `OFF_DATA_B:     data_b_next     = bus_wdata;
            `OFF_DATA_C:     data_c_next     = bus_wdata;
            `OFF_DATA_D:     data_d_next     = bus_wdata;
            `OFF_DIR_A:      dir_a_next      = bus_wdata;
            `OFF_DIR_B:      dir_b_next      = bus_wdata;
            `OFF_DIR_C:      dir_c_next      = bus_wdata;
            `OFF_DIR_D:      dir_d_next      = bus_wdata;
            `OFF_WAKE_EN:    wake_en_next    = bus_wdata;
            `OFF_DRIVE_LOW:  drive_low_next  = bus_wdata;
            `OFF_DRIVE_HIGH: drive_high_next = bus_wdata;
            `OFF_HALT_CTRL: begin
               // Writing bit 0 high halts the core
               if (bus_wdata[0]) pwr_next = gpio_pkg::HALT_MODE;
            end
            `OFF_IRQ_MASK:   irq_mask_next   = bus_wdata[1:0];
            default: ;
         endcase
      end
      // Read decode, unmapped reads return zero
      if (bus_rd) begin
         unique case (bus_addr)
            `OFF_DATA_A:     rdata_next = port_read(dir_a_reg, data_a_reg,
                                                    sync2_a);
            `OFF_DATA_B:     rdata_next = port_read(dir_b_reg, data_b_reg,
                                                    sync2_b);
            `OFF_DATA_C:     rdata_next = port_read(dir_c_reg, data_c_reg,
                                                    sync2_c);
            `OFF_DATA_D:     rdata_next = port_read(dir_d_reg, data_d_reg,
                                                    sync2_d);
            `OFF_DIR_A:      rdata_next = dir_a_reg;
            `OFF_DIR_B:      rdata_next = dir_b_reg;
            `OFF_DIR_C:      rdata_next = dir_c_reg;
            `OFF_DIR_D:      rdata_next = dir_d_reg;
            `OFF_WAKE_EN:    rdata_next = wake_en_reg;
            `OFF_DRIVE_LOW:  rdata_next = drive_low_reg;
            `OFF_DRIVE_HIGH: rdata_next = drive_high_reg;
            `OFF_HALT_CTRL:  rdata_next = {7'h00,
                                 pwr_reg == gpio_pkg::HALT_MODE};
            `OFF_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
            `OFF_IRQ_MASK:   rdata_next = {6'h00, irq_mask_reg};
            default:         rdata_next = 8'h00;
         endcase
      end
      // Any qualified edge ends the halt with one wake pulse
      if (pwr_reg == gpio_pkg::HALT_MODE && |wake_hit) begin
         pwr_next  = gpio_pkg::RUN_MODE;
         wake_next = 1'b1;
      end
      events[`BIT_IRQ_WAKE] = pwr_reg == gpio_pkg::HALT_MODE && |wake_hit;
      events[`BIT_IRQ_EDGE] = |(fall_a & wake_en_reg & dir_a_reg);
      // Write one to clear, set wins over clear
      irq_status_next = irq_status_reg;
      if (bus_wr && bus_addr == `OFF_IRQ_STATUS)
         irq_status_next = irq_status_reg & ~bus_wdata[1:0];
      irq_status_next = irq_status_next | events;
   end

   // Register update
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_a_reg     <= `RST_DATA;
         data_b_reg     <= `RST_DATA;
         data_c_reg     <= `RST_DATA;
         data_d_reg     <= `RST_DATA;
         dir_a_reg      <= `RST_DIR;
         dir_b_reg      <= `RST_DIR;
         dir_c_reg      <= `RST_DIR;
         dir_d_reg      <= `RST_DIR;
         wake_en_reg    <= `RST_WAKE_EN;
         drive_low_reg  <= `RST_DRIVE;
         drive_high_reg <= `RST_DRIVE;
         irq_status_reg <= 2'h0;
         irq_mask_reg   <= 2'h0;
         pwr_reg        <= gpio_pkg::RUN_MODE;
         wake_reg       <= 1'b0;
         rdata_reg      <= 8'h00;
      end else begin
         data_a_reg     <= data_a_next;
         data_b_reg     <= data_b_next;
         data_c_reg     <= data_c_next;
         data_d_reg     <= data_d_next;
         dir_a_reg      <= dir_a_next;
         dir_b_reg      <= dir_b_next;
         dir_c_reg      <= dir_c_next;
         dir_d_reg      <= dir_d_next;
         wake_en_reg    <= wake_en_next;
         drive_low_reg  <= drive_low_next;
         drive_high_reg <= drive_high_next;
         irq_status_reg <= irq_status_next;
         irq_mask_reg   <= irq_mask_next;
         pwr_reg        <= pwr_next;
         wake_reg       <= wake_next;
         rdata_reg      <= rdata_next;
      end
   end

   // Per-pin drive level: group field when output and in a group, else level 0
   function automatic logic [2*PORT_W-1:0] drive_map(
      input logic [PORT_W-1:0] dir,
      input logic [1:0]        hi_sel,
      input logic [1:0]        lo_sel,
      input logic [PORT_W-1:0] hi_pins,
      input logic [PORT_W-1:0] lo_pins
   );
      drive_map = '0;
      for (int i = 0; i < PORT_W; i++) begin
         if (!dir[i] && hi_pins[i]) drive_map[2*i +: 2] = hi_sel;
         if (!dir[i] && lo_pins[i]) drive_map[2*i +: 2] = lo_sel;
      end
   endfunction

   // Output pin and drive registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_a_out     <= '0;
         pin_b_out     <= '0;
         pin_c_out     <= '0;
         pin_d_out     <= '0;
         pin_a_oe_n    <= '1;
         pin_b_oe_n    <= '1;
         pin_c_oe_n    <= '1;
         pin_d_oe_n    <= '1;
         drive_a_level <= '0;
         drive_b_level <= '0;
         drive_c_level <= '0;
         halted        <= 1'b0;
         wake_req      <= 1'b0;
         irq           <= 1'b0;
         bus_rdata     <= 8'h00;
      end else begin
         pin_a_out     <= data_a_reg;
         pin_b_out     <= data_b_reg;
         pin_c_out     <= data_c_reg;
         pin_d_out     <= data_d_reg;
         pin_a_oe_n    <= dir_a_reg;
         pin_b_oe_n    <= dir_b_reg;
         pin_c_oe_n    <= dir_c_reg;
         pin_d_oe_n    <= dir_d_reg;
         drive_a_level <= drive_map(dir_a_reg,
            drive_low_reg[`DRV_A_HI_POS +: 2],
            drive_low_reg[`DRV_A_LO_POS +: 2], 8'hf0, 8'h0f);
         drive_b_level <= drive_map(dir_b_reg,
            drive_low_reg[`DRV_B_HI_POS +: 2],
            drive_low_reg[`DRV_B_LO_POS +: 2], 8'h70, 8'h0b);
         drive_c_level <= drive_map(dir_c_reg,
            drive_high_reg[`DRV_C_HI_POS +: 2],
            drive_high_reg[`DRV_C_LO_POS +: 2], 8'h70, 8'h0f);
         halted        <= pwr_reg == gpio_pkg::HALT_MODE;
         wake_req      <= wake_reg;
         irq           <= |(irq_status_next & irq_mask_next);
         bus_rdata     <= rdata_next;
      end
   end

endmodule // gpio_direction_wake_drive

/* bench/gpio_port_sva.sv */
// Port-level checks bound onto the GPIO port block
`timescale 1ns/1ns
`include "gpio_consts.svh"
module gpio_port_sva #(
   parameter int PORT_W = 8
) (
   input wire logic                sys_clk,
   input wire logic                rst_n,
   input wire logic                bus_wr,
   input wire logic                bus_rd,
   input wire logic                halted,
   input wire logic                wake_req,
   input wire logic                irq,
   input wire logic [`ADDR_W-1:0]  bus_addr,
   input wire logic [7:0]          bus_wdata,
   input wire logic [7:0]          bus_rdata,
   input wire logic [PORT_W-1:0]   pin_a_out,
   input wire logic [PORT_W-1:0]   pin_a_oe_n,
   input wire logic [2*PORT_W-1:0] drive_a_level
);
   // One clock domain, one reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Read data stays zero outside the answer cycle
   property p_rdata_idle;
      !$past(bus_rd) |-> bus_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
   // Direction write reaches the enables two cycles on
   property p_dir_oe;
      (bus_wr && bus_addr == `OFF_DIR_A) ##1
      !(bus_wr && bus_addr == `OFF_DIR_A) |=>
      pin_a_oe_n == $past(bus_wdata, 2);
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("enable mismatch");
   // Latch write reaches the pins two cycles on
   property p_latch_val;
      (bus_wr && bus_addr == `OFF_DATA_A) ##1
      !(bus_wr && bus_addr == `OFF_DATA_A) |=>
      pin_a_out == $past(bus_wdata, 2);
   endproperty
   a_latch_val: assert property (p_latch_val)
      else $error("latch value");
   // Latch only moves after a data write
   property p_latch_hold;
      $changed(pin_a_out) |-> $past(bus_wr && bus_addr == `OFF_DATA_A, 2);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch moved");
   // No drive level on port A pin 0 while it is an input
   property p_drive_input;
      pin_a_oe_n[0] |-> drive_a_level[1:0] == 2'b00;
   endproperty
   a_drive_input: assert property (p_drive_input)
      else $error("input driven");
   // Wake request is a lone pulse
   property p_wake_single;
      wake_req |=> !wake_req;
   endproperty
   a_wake_single: assert property (p_wake_single)
      else $error("long wake");
   // Wake only comes out of the halted state
   property p_wake_halted;
      wake_req |-> $past(halted);
   endproperty
   a_wake_halted: assert property (p_wake_halted)
      else $error("wake unhalted");
   // Leaving halt always comes with a wake request
   property p_wake_leave;
      $fell(halted) |-> wake_req;
   endproperty
   a_wake_leave: assert property (p_wake_leave)
      else $error("silent leave");
   // Clearing the mask silences the interrupt
   property p_mask_off;
      bus_wr && bus_addr == `OFF_IRQ_MASK && bus_wdata == 8'h00 |-> ##2 !irq;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq unmasked");
endmodule // gpio_port_sva
bind gpio_direction_wake_drive gpio_port_sva #(.PORT_W(PORT_W)) chk (
   .sys_clk, .rst_n, .bus_wr, .bus_rd, .halted, .wake_req, .irq, .bus_addr,
   .bus_wdata, .bus_rdata, .pin_a_out, .pin_a_oe_n, .drive_a_level);

/* bench/pin_side.sv */
// Switches and monitor lines seen at one port's pins
`timescale 1ns/1ns
module pin_side (
   input  wire logic [7:0] out_v, // Levels the block drives
   input  wire logic [7:0] oe_n,  // Low where the block drives
   input  wire logic [7:0] sw,    // Far-side switch levels
   output logic      [7:0] level  // Resolved pin levels
);
   // Driven pins follow the block, released pins the switches
   assign level = (~oe_n & out_v) | (oe_n & sw);
endmodule // pin_side

/* bench/gpio_direction_wake_drive_test.sv */
// Random and corner-case bench for the GPIO port block
`timescale 1ns/1ns
`include "gpio_consts.svh"
module gpio_direction_wake_drive_test;
   logic        sys_clk = 1'b0, rst_n = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
   logic [4:0]  bus_addr = 5'h00;
   logic [7:0]  bus_wdata = 8'h00, bus_rdata, rd_v, hi_v, exp_v;
   logic [7:0]  sw [4] = '{default: 8'hff}; // Switch levels
   logic [7:0]  pin_in [4], pin_out [4], oe_n [4], dir [4], lat [4];
   logic [15:0] drv [3];                     // Drive level outputs
   logic [1:0]  c;                           // Drive code under test
   logic        halted, wake_req, irq;
   int          n_fail = 0, n_tests = 0, seed = 16994, k, i;
   // Block under test
   gpio_direction_wake_drive dut (.sys_clk, .rst_n, .bus_addr, .bus_wdata,
      .bus_wr, .bus_rd, .bus_rdata, .pin_a_in(pin_in[0]),
      .pin_b_in(pin_in[1]), .pin_c_in(pin_in[2]), .pin_d_in(pin_in[3]),
      .pin_a_out(pin_out[0]), .pin_b_out(pin_out[1]), .pin_c_out(pin_out[2]),
      .pin_d_out(pin_out[3]), .pin_a_oe_n(oe_n[0]), .pin_b_oe_n(oe_n[1]),
      .pin_c_oe_n(oe_n[2]), .pin_d_oe_n(oe_n[3]), .drive_a_level(drv[0]),
      .drive_b_level(drv[1]), .drive_c_level(drv[2]), .halted, .wake_req,
      .irq);
   // Far side of each port
   for (genvar g = 0; g < 4; g++) begin : g_side
      pin_side ps (.out_v(pin_out[g]), .oe_n(oe_n[g]), .sw(sw[g]),
         .level(pin_in[g]));
   end
   // Clock
   always #50 sys_clk = ~sys_clk;
   // Register write, one strobe cycle
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   // Register read, data taken in the answer cycle
   task automatic rd(input logic [4:0] a);
      @(posedge sys_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      @(negedge sys_clk);
      rd_v = bus_rdata;
   endtask
   // Compare any value
   task automatic chk(input logic [15:0] got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Expected drive levels of one port
   function automatic logic [15:0] drv_exp(input logic [7:0] d, hm, lm,
                                           input logic [1:0] hs, ls);
      logic [15:0] e;
      for (int j = 0; j < 8; j++)
         e[2*j+:2] = d[j] ? 2'b00 : hm[j] ? hs : lm[j] ? ls : 2'b00;
      return e;
   endfunction
   // Counts, verdict and end of run
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (k = 0; k < 4; k++) begin
         rd(`OFF_DIR_A + 5'(k));
         chk(rd_v, `RST_DIR, "dir reset");
      end
      rd(`OFF_WAKE_EN);
      chk(rd_v, `RST_WAKE_EN, "wake reset");
      rd(5'h1f);
      chk(rd_v, 8'h00, "unmapped");
      $display("test reset done");
      for (i = 0; i < 24; i++) begin
         for (k = 0; k < 4; k++) begin
            dir[k] = 8'($random(seed));
            lat[k] = 8'($random(seed));
            wr(`OFF_DIR_A + 5'(k), dir[k]);
            wr(`OFF_DATA_A + 5'(k), lat[k]);
            // Switches move just after a rising edge
            sw[k] <= 8'($random(seed));
         end
         repeat (4) @(posedge sys_clk);
         for (k = 0; k < 4; k++) begin
            rd(`OFF_DATA_A + 5'(k));
            exp_v = (dir[k] & sw[k]) | (~dir[k] & lat[k]);
            chk(rd_v, exp_v, "data");
            chk(oe_n[k], dir[k], "enable");
            chk(pin_out[k], lat[k], "latch out");
         end
      end
      wr(`OFF_DIR_B, 8'hfb);
      wr(`OFF_DIR_D, 8'hf2);
      wr(`OFF_DIR_D, 8'hf0);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(oe_n[3], 8'hf0, "serial dir");
      $display("test direction done");
      for (i = 0; i < 4; i++) begin
         c = 2'(i);
         // Reserved upper bits stay at their power-on value
         hi_v = {4'h0, ~c, c};
         for (k = 0; k < 3; k++) begin
            dir[k] = 8'($random(seed));
            wr(`OFF_DIR_A + 5'(k), dir[k]);
         end
         wr(`OFF_DRIVE_LOW, {c, ~c, ~c, c});
         wr(`OFF_DRIVE_HIGH, hi_v);
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(drv[0], drv_exp(dir[0], 8'hf0, 8'h0f, ~c, c), "drv a");
         chk(drv[1], drv_exp(dir[1], 8'h70, 8'h0b, c, ~c), "drv b");
         chk(drv[2], drv_exp(dir[2], 8'h70, 8'h0f, ~c, c), "drv c");
         rd(`OFF_DRIVE_HIGH);
         chk(rd_v, hi_v, "upper bits");
      end
      $display("test drive done");
      wr(`OFF_DIR_A, 8'hff);
      sw[0] <= 8'hff;
      wr(`OFF_WAKE_EN, 8'h01);
      wr(`OFF_IRQ_MASK, 8'h01);
      wr(`OFF_IRQ_STATUS, 8'hff);
      wr(`OFF_HALT_CTRL, 8'h01);
      sw[0] <= 8'hfd;
      repeat (8) @(negedge sys_clk);
      chk(halted, 1'b1, "disabled pin woke");
      @(posedge sys_clk);
      sw[0] <= 8'hfc;
      for (k = 0; k < 20 && wake_req !== 1'b1; k++) @(negedge sys_clk);
      // A wake that never comes counts against the run
      if (k == 20) begin
         n_fail++;
         $display("mismatch at %0t: wake timeout", $time);
      end
      chk(halted, 1'b0, "still halted");
      repeat (2) @(negedge sys_clk);
      chk(irq, 1'b1, "wake irq");
      rd(`OFF_IRQ_STATUS);
      chk(rd_v[0], 1'b1, "wake status");
      wr(`OFF_IRQ_STATUS, 8'h03);
      repeat (2) @(negedge sys_clk);
      chk(irq, 1'b0, "irq cleared");
      $display("test wake done");
      // Enabled edge while running sets the edge event only
      wr(`OFF_IRQ_MASK, 8'h02);
      sw[0] <= 8'hff;
      repeat (3) @(posedge sys_clk);
      sw[0] <= 8'hfe;
      repeat (6) @(negedge sys_clk);
      chk(irq, 1'b1, "edge irq");
      chk(halted, 1'b0, "edge halted");
      // Clearing the mask drops the interrupt, status stays
      wr(`OFF_IRQ_MASK, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk(irq, 1'b0, "irq masked");
      rd(`OFF_IRQ_STATUS);
      chk(rd_v, 8'h02, "edge status");
      $display("test mask done");
      print_verdict();
   end
endmodule // gpio_direction_wake_drive_test
